/* core/clock_select_and_module_stop.sv */
// Purpose: clock ratio selection and module-stop gating for on-chip units
// Assumes: single ref_clk domain; sleep and wake come from core logic
// Notes: registers sit at their printed addresses on a plain port
//
// Functional notes
// R1 - core clock ratio from bits 10..8, 010 unity
// R2 - peripheral clock ratio from bits 6..4
// R3 - external bus clock ratio from bits 2..0
// R4 - stop bit 1 halts module, 0 resumes
// R5 - first register bit 15 enables all-clock halt
// R6 - sleep halts bus/io only when all stopped
// R7 - first register stop bit map
// R8 - second register stop bit map
// R9 - third register bit 15 serial five
// R10 - third register bits 14..10 map
// R11 - third register bits 4..0 ram blocks
`timescale 1ns/100ps
module clock_select_and_module_stop (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [23:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic sleep_exec,
  input wire logic wake_req,
  output logic core_clk_tick,
  output logic periph_clk_tick,
  output logic ext_bus_clk_tick,
  output logic bus_io_halt,
  output logic halt_dma_engine,
  output logic halt_transfer_controller,
  output logic halt_timer_pair_32,
  output logic halt_timer_pair_10,
  output logic halt_dac,
  output logic halt_adc,
  output logic halt_pulse_timers,
  output logic halt_pulse_generator,
  output logic halt_serial_4,
  output logic halt_serial_2,
  output logic halt_serial_1,
  output logic halt_serial_0,
  output logic halt_i2c_1,
  output logic halt_i2c_0,
  output logic halt_serial_5,
  output logic halt_serial_6,
  output logic halt_timer_pair_45,
  output logic halt_timer_pair_67,
  output logic halt_usb,
  output logic halt_crc_checker,
  output logic [4:0] halt_ram_block
);
  clk_ctrl_pkg::reg_req_t req;
  logic [15:0] ratio_reg;
  logic [15:0] first_reg;
  logic [15:0] second_reg;
  logic [15:0] third_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [2:0] sel [3];
  logic [2:0] ticks;
  logic all_stopped;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // register writes; unimplemented bits never store
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ratio_reg <= clk_ctrl_pkg::RATIO_RESET;
    else if (clk_en && req.wr && req.addr == clk_ctrl_pkg::SYS_CLK_RATIO_OFS)
      ratio_reg <= req.wdata & clk_ctrl_pkg::RATIO_MASK; // R1 R2 R3
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      first_reg <= clk_ctrl_pkg::FIRST_RESET;
    else if (clk_en && req.wr && req.addr == clk_ctrl_pkg::STOP_FIRST_OFS)
      first_reg <= req.wdata & clk_ctrl_pkg::FIRST_MASK; // R4 R5
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      second_reg <= clk_ctrl_pkg::SECOND_RESET;
    else if (clk_en && req.wr && req.addr == clk_ctrl_pkg::STOP_SECOND_OFS)
      second_reg <= req.wdata & clk_ctrl_pkg::SECOND_MASK; // R4
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      third_reg <= clk_ctrl_pkg::THIRD_RESET;
    else if (clk_en && req.wr && req.addr == clk_ctrl_pkg::STOP_THIRD_OFS)
      third_reg <= req.wdata & clk_ctrl_pkg::THIRD_MASK; // R4
  end

  // unmapped addresses read as zero
  always_comb
  begin
    rdata_next = 16'h0000;
    if (req.rd)
    begin
      unique case (req.addr)
        clk_ctrl_pkg::SYS_CLK_RATIO_OFS: rdata_next = ratio_reg;
        clk_ctrl_pkg::STOP_FIRST_OFS: rdata_next = first_reg;
        clk_ctrl_pkg::STOP_SECOND_OFS: rdata_next = second_reg;
        clk_ctrl_pkg::STOP_THIRD_OFS: rdata_next = third_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_reg <= 16'h0000;
    else if (clk_en)
      rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

  // ratio selectors, one tick stream each
  assign sel[0] = ratio_reg[clk_ctrl_pkg::CORE_SEL_LSB +: 3]; // R1
  assign sel[1] = ratio_reg[clk_ctrl_pkg::PERIPH_SEL_LSB +: 3]; // R2
  assign sel[2] = ratio_reg[clk_ctrl_pkg::EXT_BUS_SEL_LSB +: 3]; // R3

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_tick
      ratio_tick u_tick (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .sel(sel[i]),
        .tick(ticks[i])
      );
    end
  endgenerate

  assign core_clk_tick = ticks[0];
  assign periph_clk_tick = ticks[1];
  assign ext_bus_clk_tick = ticks[2];

  // ram blocks are not peripherals, so they do not gate the halt
  assign all_stopped =
    ((first_reg & clk_ctrl_pkg::FIRST_PERIPH_MASK)
      == clk_ctrl_pkg::FIRST_PERIPH_MASK) &&
    (second_reg == clk_ctrl_pkg::SECOND_MASK) &&
    ((third_reg & clk_ctrl_pkg::THIRD_PERIPH_MASK)
      == clk_ctrl_pkg::THIRD_PERIPH_MASK); // R6

  sleep_halt u_halt (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .all_halt_enable(first_reg[clk_ctrl_pkg::ALL_HALT_BIT]), // R5
    .all_stopped(all_stopped),
    .sleep_exec(sleep_exec),
    .wake_req(wake_req),
    .halted(bus_io_halt)
  );

  // stop outputs straight from register flops
  assign halt_dma_engine = first_reg[clk_ctrl_pkg::DMA_BIT]; // R7
  assign halt_transfer_controller = first_reg[clk_ctrl_pkg::XFER_CTRL_BIT]; // R7
  assign halt_timer_pair_32 = first_reg[clk_ctrl_pkg::TIMER_32_BIT]; // R7
  assign halt_timer_pair_10 = first_reg[clk_ctrl_pkg::TIMER_10_BIT]; // R7
  assign halt_dac = first_reg[clk_ctrl_pkg::DAC_BIT]; // R7
  assign halt_adc = first_reg[clk_ctrl_pkg::ADC_BIT]; // R7
  assign halt_pulse_timers = first_reg[clk_ctrl_pkg::PULSE_TIMER_BIT]; // R7
  assign halt_pulse_generator = second_reg[clk_ctrl_pkg::PULSE_GEN_BIT]; // R8
  assign halt_serial_4 = second_reg[clk_ctrl_pkg::SERIAL_4_BIT]; // R8
  assign halt_serial_2 = second_reg[clk_ctrl_pkg::SERIAL_2_BIT]; // R8
  assign halt_serial_1 = second_reg[clk_ctrl_pkg::SERIAL_1_BIT]; // R8
  assign halt_serial_0 = second_reg[clk_ctrl_pkg::SERIAL_0_BIT]; // R8
  assign halt_i2c_1 = second_reg[clk_ctrl_pkg::I2C_1_BIT]; // R8
  assign halt_i2c_0 = second_reg[clk_ctrl_pkg::I2C_0_BIT]; // R8
  assign halt_serial_5 = third_reg[clk_ctrl_pkg::SERIAL_5_BIT]; // R9
  assign halt_serial_6 = third_reg[clk_ctrl_pkg::SERIAL_6_BIT]; // R10
  assign halt_timer_pair_45 = third_reg[clk_ctrl_pkg::TIMER_45_BIT]; // R10
  assign halt_timer_pair_67 = third_reg[clk_ctrl_pkg::TIMER_67_BIT]; // R10
  assign halt_usb = third_reg[clk_ctrl_pkg::USB_BIT]; // R10
  assign halt_crc_checker = third_reg[clk_ctrl_pkg::CRC_BIT]; // R10
  // bit 0 is the highest 8 KB block
  assign halt_ram_block = third_reg[clk_ctrl_pkg::RAM_BLOCKS-1:0]; // R11

  // checks
  chk_core_unity_tick: assert property ( // R1
    @(posedge ref_clk) disable iff (!resetn)
    (resetn && clk_en && sel[0] == clk_ctrl_pkg::SEL_UNITY)
      |=> core_clk_tick)
    else $error("core tick missing at unity ratio");

  chk_periph_div_two: assert property ( // R2
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && sel[1] == 3'h3 && periph_clk_tick)
      ##1 (clk_en && sel[1] == 3'h3) |=> periph_clk_tick)
    else $error("peripheral tick not halved");

  chk_periph_tick_gap: assert property ( // R2
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && sel[1] == 3'h3 && periph_clk_tick) |=> !periph_clk_tick)
    else $error("peripheral tick not followed by a gap");

  chk_ext_unity_tick: assert property ( // R3
    @(posedge ref_clk) disable iff (!resetn)
    (resetn && clk_en && sel[2] == clk_ctrl_pkg::SEL_UNITY)
      |=> ext_bus_clk_tick)
    else $error("external bus tick missing at unity ratio");

  chk_stop_write_one: assert property ( // R4
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_FIRST_OFS)
      |=> (halt_dma_engine == $past(reg_wdata[13])) &&
          (halt_pulse_timers == $past(reg_wdata[0])))
    else $error("first stop write not applied");

  chk_all_halt_read: assert property ( // R5
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_rd && reg_addr == clk_ctrl_pkg::STOP_FIRST_OFS)
      |=> reg_rdata[15] == first_reg[clk_ctrl_pkg::ALL_HALT_BIT])
    else $error("all-halt enable readback wrong");

  chk_halt_cause: assert property ( // R6
    @(posedge ref_clk) disable iff (!resetn)
    $rose(bus_io_halt) |->
      $past(sleep_exec && all_stopped && first_reg[15] && clk_en))
    else $error("bus halt without its cause");

  chk_halt_entry: assert property ( // R6
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && !bus_io_halt && sleep_exec && all_stopped &&
      first_reg[15]) |=> bus_io_halt)
    else $error("bus halt not entered on sleep");

  chk_first_map: assert property ( // R7
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_FIRST_OFS)
      |=> halt_transfer_controller == $past(reg_wdata[12]) &&
          halt_adc == $past(reg_wdata[3]))
    else $error("first stop map wrong");

  chk_second_map: assert property ( // R8
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_SECOND_OFS)
      |=> halt_i2c_0 == $past(reg_wdata[6]) &&
          halt_pulse_generator == $past(reg_wdata[15]))
    else $error("second stop map wrong");

  chk_serial5_map: assert property ( // R9
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_THIRD_OFS)
      |=> halt_serial_5 == $past(reg_wdata[15]))
    else $error("serial five stop wrong");

  chk_third_map: assert property ( // R10
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_THIRD_OFS)
      |=> halt_usb == $past(reg_wdata[11]) &&
          halt_crc_checker == $past(reg_wdata[10]))
    else $error("third stop map wrong");

  chk_ram_map: assert property ( // R11
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_THIRD_OFS)
      |=> halt_ram_block == $past(reg_wdata[4:0]))
    else $error("ram block stop wrong");

  chk_core_tick_gap: assert property ( // R1
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && sel[0] == 3'h3 && core_clk_tick) |=> !core_clk_tick)
    else $error("core tick not followed by a gap");

  chk_ext_tick_gap: assert property ( // R3
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && sel[2] == 3'h3 && ext_bus_clk_tick) |=> !ext_bus_clk_tick)
    else $error("external bus tick not followed by a gap");

  chk_periph_unity_tick: assert property ( // R2
    @(posedge ref_clk) disable iff (!resetn)
    (resetn && clk_en && sel[1] == clk_ctrl_pkg::SEL_UNITY)
      |=> periph_clk_tick)
    else $error("peripheral tick missing at unity ratio");

  chk_ratio_readback: assert property ( // R1
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_rd && reg_addr == clk_ctrl_pkg::SYS_CLK_RATIO_OFS)
      |=> reg_rdata == ratio_reg)
    else $error("ratio register readback wrong");

  chk_second_write: assert property ( // R4
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_SECOND_OFS)
      |=> (halt_serial_0 == $past(reg_wdata[8])) &&
          (halt_serial_4 == $past(reg_wdata[12])))
    else $error("second stop write not applied");

  chk_third_write: assert property ( // R4
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_THIRD_OFS)
      |=> (halt_serial_6 == $past(reg_wdata[14])) &&
          (halt_timer_pair_45 == $past(reg_wdata[13])))
    else $error("third stop write not applied");

  chk_first_timers: assert property ( // R7
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_FIRST_OFS)
      |=> (halt_timer_pair_32 == $past(reg_wdata[9])) &&
          (halt_timer_pair_10 == $past(reg_wdata[8])) &&
          (halt_dac == $past(reg_wdata[5])))
    else $error("first stop timer map wrong");

  chk_second_serial: assert property ( // R8
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_SECOND_OFS)
      |=> (halt_serial_2 == $past(reg_wdata[10])) &&
          (halt_serial_1 == $past(reg_wdata[9])) &&
          (halt_i2c_1 == $past(reg_wdata[7])))
    else $error("second stop serial map wrong");

  chk_timer_67_map: assert property ( // R10
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_THIRD_OFS)
      |=> halt_timer_pair_67 == $past(reg_wdata[12]))
    else $error("third stop timer map wrong");

  chk_all_halt_write: assert property ( // R5
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == clk_ctrl_pkg::STOP_FIRST_OFS)
      |=> first_reg[clk_ctrl_pkg::ALL_HALT_BIT] == $past(reg_wdata[15]))
    else $error("all-halt enable write lost");

  chk_stop_freeze: assert property ( // R4
    @(posedge ref_clk) disable iff (!resetn)
    !clk_en |=> $stable(first_reg) && $stable(second_reg) &&
      $stable(third_reg) && $stable(ratio_reg))
    else $error("register changed with clock enable low");

  chk_halt_hold: assert property ( // R6
    @(posedge ref_clk) disable iff (!resetn)
    (bus_io_halt && !(clk_en && wake_req)) |=> bus_io_halt)
    else $error("bus halt dropped without wake");

  chk_wake_exit: assert property ( // R6
    @(posedge ref_clk) disable iff (!resetn)
    (clk_en && bus_io_halt && wake_req) |=> !bus_io_halt)
    else $error("bus halt kept after wake");

  chk_halt_disabled: assert property ( // R5
    @(posedge ref_clk) disable iff (!resetn)
    (!bus_io_halt && !first_reg[clk_ctrl_pkg::ALL_HALT_BIT])
      |=> !bus_io_halt)
    else $error("bus halt entered while disabled");
endmodule

/* common/clk_ctrl_pkg.sv */
// Purpose: shared constants and types for clock ratio and module-stop control
// Assumes: 16-bit registers reached at their printed byte addresses
// Notes: reset values are a local choice; no initial values are printed
package clk_ctrl_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int SEL_W = 3;
  localparam int CNT_W = 3;

  // register addresses
  localparam logic [23:0] SYS_CLK_RATIO_OFS = 24'hff_fdc4;
  localparam logic [23:0] STOP_FIRST_OFS = 24'hff_fdc8;
  localparam logic [23:0] STOP_SECOND_OFS = 24'hff_fdca;
  localparam logic [23:0] STOP_THIRD_OFS = 24'hff_fdcc;

  // ratio selector fields
  localparam int CORE_SEL_LSB = 8;
  localparam int PERIPH_SEL_LSB = 4;
  localparam int EXT_BUS_SEL_LSB = 0;
  localparam logic [2:0] SEL_UNITY = 3'h2;
  localparam logic [2:0] SEL_DIV_MAX = 3'h5;

  // first stop register
  localparam int ALL_HALT_BIT = 15;
  localparam int DMA_BIT = 13;
  localparam int XFER_CTRL_BIT = 12;
  localparam int TIMER_32_BIT = 9;
  localparam int TIMER_10_BIT = 8;
  localparam int DAC_BIT = 5;
  localparam int ADC_BIT = 3;
  localparam int PULSE_TIMER_BIT = 0;
  // second stop register
  localparam int PULSE_GEN_BIT = 15;
  localparam int SERIAL_4_BIT = 12;
  localparam int SERIAL_2_BIT = 10;
  localparam int SERIAL_1_BIT = 9;
  localparam int SERIAL_0_BIT = 8;
  localparam int I2C_1_BIT = 7;
  localparam int I2C_0_BIT = 6;
  // third stop register
  localparam int SERIAL_5_BIT = 15;
  localparam int SERIAL_6_BIT = 14;
  localparam int TIMER_45_BIT = 13;
  localparam int TIMER_67_BIT = 12;
  localparam int USB_BIT = 11;
  localparam int CRC_BIT = 10;
  localparam int RAM_BLOCKS = 5;

  // implemented bits; all others read zero
  localparam logic [15:0] RATIO_MASK = 16'h0777;
  localparam logic [15:0] FIRST_MASK = 16'hb329;
  localparam logic [15:0] FIRST_PERIPH_MASK = 16'h3329;
  localparam logic [15:0] SECOND_MASK = 16'h97c0;
  localparam logic [15:0] THIRD_MASK = 16'hfc1f;
  localparam logic [15:0] THIRD_PERIPH_MASK = 16'hfc00;

  localparam logic [15:0] RATIO_RESET = 16'h0222;
  localparam logic [15:0] FIRST_RESET = 16'h3329;
  localparam logic [15:0] SECOND_RESET = 16'h97c0;
  localparam logic [15:0] THIRD_RESET = 16'hfc00;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic {RUN_ST, HALT_ST} halt_state_t;
endpackage

/* core/ratio_tick.sv */
// Purpose: one clock-enable tick stream from a three-bit ratio selector
// Assumes: a multiplying code cannot exceed ref_clk, so it runs at x1
// Notes: codes 3 to 5 divide by 2, 4 and 8
`timescale 1ns/100ps
module ratio_tick (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [2:0] cnt_reg;
  logic [2:0] limit;
  logic tick_reg;

  always_comb
  begin
    if (sel > clk_ctrl_pkg::SEL_UNITY && sel <= clk_ctrl_pkg::SEL_DIV_MAX)
      limit = 3'((3'h1 << (sel - clk_ctrl_pkg::SEL_UNITY)) - 3'h1);
    else
      limit = 3'h0;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_reg <= 3'h0;
    else if (clk_en)
      cnt_reg <= (cnt_reg >= limit) ? 3'h0 : cnt_reg + 3'h1;
  end

  // >= so that a ratio change mid-count never stalls the stream
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tick_reg <= 1'b0;
    else if (clk_en)
      tick_reg <= (cnt_reg >= limit);
  end

  assign tick = tick_reg;
endmodule

/* core/sleep_halt.sv */
// Purpose: bus controller and i/o port halt on sleep in all-stop mode
// Assumes: sleep and wake requests come from logic on ref_clk
// Notes: halt stays until a wake request
`timescale 1ns/100ps
module sleep_halt (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic all_halt_enable,
  input wire logic all_stopped,
  input wire logic sleep_exec,
  input wire logic wake_req,
  output logic halted
);
  clk_ctrl_pkg::halt_state_t state_reg;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= clk_ctrl_pkg::RUN_ST;
    else if (clk_en)
    begin
      unique case (state_reg)
        clk_ctrl_pkg::RUN_ST:
          if (sleep_exec && all_halt_enable && all_stopped)
            state_reg <= clk_ctrl_pkg::HALT_ST;
        clk_ctrl_pkg::HALT_ST:
          if (wake_req)
            state_reg <= clk_ctrl_pkg::RUN_ST;
      endcase
    end
  end

  assign halted = (state_reg == clk_ctrl_pkg::HALT_ST);
endmodule

/* bench/clock_select_and_module_stop_test.sv */
// Purpose: self-checking bench for clock ratio and module-stop control
// Assumes: reset values and divide ratios as handed over by the designer
// Notes: tick counts use 32-cycle windows, so divider phase does not matter
`timescale 1ns/100ps
module clock_select_and_module_stop_test;
  logic ref_clk, resetn, clk_en, reg_wr, reg_rd, sleep_exec, wake_req;
  logic [23:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic core_clk_tick, periph_clk_tick, ext_bus_clk_tick, bus_io_halt;
  logic halt_dma_engine, halt_transfer_controller, halt_timer_pair_32;
  logic halt_timer_pair_10, halt_dac, halt_adc, halt_pulse_timers;
  logic halt_pulse_generator, halt_serial_4, halt_serial_2, halt_serial_1;
  logic halt_serial_0, halt_i2c_1, halt_i2c_0, halt_serial_5, halt_serial_6;
  logic halt_timer_pair_45, halt_timer_pair_67, halt_usb, halt_crc_checker;
  logic [4:0] halt_ram_block;
  int err_total, checked;
  // halt outputs gathered back into register bit positions
  wire [15:0] first_out = {2'h0, halt_dma_engine, halt_transfer_controller,
    2'h0, halt_timer_pair_32, halt_timer_pair_10, 2'h0, halt_dac, 1'b0,
    halt_adc, 2'h0, halt_pulse_timers};
  wire [15:0] second_out = {halt_pulse_generator, 2'h0, halt_serial_4, 1'b0,
    halt_serial_2, halt_serial_1, halt_serial_0, halt_i2c_1, halt_i2c_0,
    6'h00};
  wire [15:0] third_out = {halt_serial_5, halt_serial_6, halt_timer_pair_45,
    halt_timer_pair_67, halt_usb, halt_crc_checker, 5'h00, halt_ram_block};
  logic [23:0] ofs [3];
  logic [15:0] rmask [3], omask [3], pats [3];

  clock_select_and_module_stop uut (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_exec(sleep_exec), .wake_req(wake_req),
    .core_clk_tick(core_clk_tick), .periph_clk_tick(periph_clk_tick),
    .ext_bus_clk_tick(ext_bus_clk_tick), .bus_io_halt(bus_io_halt),
    .halt_dma_engine(halt_dma_engine),
    .halt_transfer_controller(halt_transfer_controller),
    .halt_timer_pair_32(halt_timer_pair_32),
    .halt_timer_pair_10(halt_timer_pair_10), .halt_dac(halt_dac),
    .halt_adc(halt_adc), .halt_pulse_timers(halt_pulse_timers),
    .halt_pulse_generator(halt_pulse_generator),
    .halt_serial_4(halt_serial_4), .halt_serial_2(halt_serial_2),
    .halt_serial_1(halt_serial_1), .halt_serial_0(halt_serial_0),
    .halt_i2c_1(halt_i2c_1), .halt_i2c_0(halt_i2c_0),
    .halt_serial_5(halt_serial_5), .halt_serial_6(halt_serial_6),
    .halt_timer_pair_45(halt_timer_pair_45),
    .halt_timer_pair_67(halt_timer_pair_67), .halt_usb(halt_usb),
    .halt_crc_checker(halt_crc_checker), .halt_ram_block(halt_ram_block));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [23:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic pulse(input bit is_wake);
    @(posedge ref_clk);
    if (is_wake) wake_req <= 1'b1;
    else sleep_exec <= 1'b1;
    @(posedge ref_clk);
    wake_req <= 1'b0;
    sleep_exec <= 1'b0;
    #1;
  endtask

  // hang guard: a stuck run still reaches the closing report
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end

  initial
  begin
    int n0, n1, n2, exp;
    logic [15:0] cv;
    resetn = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    sleep_exec = 1'b0; wake_req = 1'b0; reg_addr = 24'h00_0000;
    reg_wdata = 16'h0000; err_total = 0; checked = 0;
    ofs = '{clk_ctrl_pkg::STOP_FIRST_OFS, clk_ctrl_pkg::STOP_SECOND_OFS,
      clk_ctrl_pkg::STOP_THIRD_OFS};
    rmask = '{clk_ctrl_pkg::FIRST_MASK, clk_ctrl_pkg::SECOND_MASK,
      clk_ctrl_pkg::THIRD_MASK};
    omask = '{clk_ctrl_pkg::FIRST_PERIPH_MASK, clk_ctrl_pkg::SECOND_MASK,
      clk_ctrl_pkg::THIRD_MASK};
    pats = '{16'hffff, 16'h0000, 16'ha5a5};
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    // reset values, unmapped places
    rd(clk_ctrl_pkg::SYS_CLK_RATIO_OFS, d); chk(d, 16'h0222);
    rd(ofs[0], d); chk(d, 16'h3329);
    rd(ofs[1], d); chk(d, 16'h97c0);
    rd(ofs[2], d); chk(d, 16'hfc00);
    chk(first_out, 16'h3329);
    chk(second_out, 16'h97c0);
    chk(third_out, 16'hfc00);
    wr(24'hff_fdc6, 16'hffff);
    rd(24'hff_fdc6, d); chk(d, 16'h0000);
    rd(clk_ctrl_pkg::STOP_FIRST_OFS, d); chk(d, 16'h3329);
    $display("test reset_and_unmapped done");
    // each stop register, several patterns, outputs follow bits
    for (int i = 0; i < 3; i++)
      for (int p = 0; p < 3; p++)
      begin
        wr(ofs[i], pats[p]);
        rd(ofs[i], d); chk(d, pats[p] & rmask[i]);
        cv = (i == 0) ? first_out : (i == 1) ? second_out : third_out;
        chk(cv, pats[p] & omask[i]);
      end
    // a write with the clock enable low is lost
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(ofs[0], 16'h0000);
    clk_en <= 1'b1;
    rd(ofs[0], d); chk(d, 16'hb329 & 16'ha5a5);
    $display("test stop_bits done");
    // every selector code in all three fields at once
    for (int c = 0; c < 8; c++)
    begin
      cv = {5'h00, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]};
      wr(clk_ctrl_pkg::SYS_CLK_RATIO_OFS, cv);
      rd(clk_ctrl_pkg::SYS_CLK_RATIO_OFS, d); chk(d, cv);
      repeat (10) @(posedge ref_clk);
      n0 = 0; n1 = 0; n2 = 0;
      repeat (32)
      begin
        @(posedge ref_clk);
        #1;
        n0 += core_clk_tick;
        n1 += periph_clk_tick;
        n2 += ext_bus_clk_tick;
      end
      exp = (c == 3) ? 16 : (c == 4) ? 8 : (c == 5) ? 4 : 32;
      chk(n0[15:0], exp[15:0]);
      chk(n1[15:0], exp[15:0]);
      chk(n2[15:0], exp[15:0]);
    end
    $display("test clock_ratio done");
    // sleep with one peripheral still running is ignored
    wr(ofs[0], 16'hb329);
    wr(ofs[1], 16'h97c0);
    wr(ofs[2], 16'hf41f);
    pulse(1'b0); chk({15'h0000, bus_io_halt}, 16'h0001 & 16'h0000);
    // all stopped, ram bits left running, enable set: halt
    wr(ofs[2], 16'hfc00);
    pulse(1'b0); chk({15'h0000, bus_io_halt}, 16'h0001);
    repeat (5) @(posedge ref_clk);
    #1 chk({15'h0000, bus_io_halt}, 16'h0001);
    pulse(1'b1); chk({15'h0000, bus_io_halt}, 16'h0000);
    // enable cleared: sleep never halts
    wr(ofs[0], 16'h3329);
    pulse(1'b0); chk({15'h0000, bus_io_halt}, 16'h0000);
    $display("test sleep_halt done");
    print_verdict();
  end
endmodule
